/* File: hdl/rsp_core.sv */
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rsp_core
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic macOverflow,
   input wire logic [15:0] macTimer,
   input wire logic [15:0] timerCompareValue,
   input wire logic ccaIn,
   input wire logic sfdIn,
   input wire logic [7:0] rngOutput,
   output logic strobeValid,
   output logic [4:0] strobeCode,
   output logic strobeImm,
   input wire logic radioAck,
   output logic radioIrq,
   output logic haltFlag,
   output logic waitDoneFlag,
   output logic programIntFlag
);
   import rsp_pkg::*;

   // ************************************************************
   // register bus
   // ************************************************************
   logic apbWr;
   logic apbRd;
   logic mapped;
   logic strobeWr;
   logic [7:0] wrByte;
   assign apbWr = psel & penable & pwrite;
   assign apbRd = psel & ~penable & ~pwrite;
   assign mapped = (paddr == OFS_STROBE) | (paddr == OFS_FIRST) | (paddr == OFS_SECOND) | (paddr == OFS_THIRD)
                 | (paddr == OFS_TIMEOUT) | (paddr == OFS_CTRL) | (paddr == OFS_STATUS);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign strobeWr = apbWr & (paddr == OFS_STROBE);
   assign wrByte = pwdata[7:0];

   rsp_state_t state_reg;
   logic [7:0] progMem [MEM_DEPTH];
   logic [4:0] pc_reg;
   logic [4:0] wrPtr_reg;
   logic [4:0] label_reg;
   logic labelValid_reg;
   logic [7:0] firstCounter_reg;
   logic [7:0] secondCounter_reg;
   logic [7:0] thirdCounter_reg;
   logic [7:0] timeout_reg;
   logic cpuCtrl_reg;
   logic [7:0] rngHeld_reg;
   logic rngStale_reg;
   logic [2:0] tickCnt_reg;
   logic tick;
   logic ovfPend_reg;
   logic [5:0] waitCnt_reg;
   logic waitArmed_reg;
   logic immPend_reg;
   logic [7:0] immOp_reg;
   logic [7:0] instr;
   logic [7:0] rdData;

   // ************************************************************
   // step rate
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (sys_rst || tickCnt_reg == TICK_LAST)
         tickCnt_reg <= 3'h0;
      else
         tickCnt_reg <= tickCnt_reg + 3'h1;
   end
   assign tick = (tickCnt_reg == TICK_LAST);

   // ************************************************************
   // step decode
   // ************************************************************
   logic stepGo;
   logic immGo;
   logic condTrue;
   logic [5:0] target;
   logic moveOn;
   logic goStrobe;
   logic progHalt;
   logic waitDone;
   logic intSet;
   logic endRun;
   logic immHalt;
   logic immLaunch;
   logic immRadio;
   logic timeoutHit;
   logic [3:0] randBits;
   logic [7:0] secondPlus;

   assign instr = progMem[pc_reg];
   assign immGo = tick & immPend_reg & (state_reg != S_STROBE) & ~strobeValid;
   assign stepGo = tick & (state_reg == S_RUN) & ~immPend_reg & ~(strobeValid & strobeImm);
   assign immHalt = immGo & (immOp_reg == OP_IMM_HALT);
   assign immLaunch = immGo & (immOp_reg == OP_IMM_LAUNCH) & (state_reg == S_IDLE);
   assign immRadio = immGo & (immOp_reg[4:0] >= STROBE_CODE_FIELD_RADIO_FIRST) & (immOp_reg[4:0] <= STROBE_CODE_FIELD_RADIO_LAST);
   assign timeoutHit = (state_reg != S_IDLE) & (timeout_reg == CNT_RESET);
   assign randBits = (secondCounter_reg == CNT_RESET || secondCounter_reg > 8'(RAND_FULL)) ? RAND_FULL
                   : secondCounter_reg[3:0];
   assign secondPlus = secondCounter_reg + 8'h01;

   always_comb
   begin
      case (instr[2:0])
         3'h0: condTrue = ccaIn;
         3'h1: condTrue = sfdIn;
         3'h2: condTrue = cpuCtrl_reg;
         3'h3: condTrue = (pc_reg == PC_LAST);
         3'h4: condTrue = (firstCounter_reg == CNT_RESET);
         3'h5: condTrue = (secondCounter_reg == CNT_RESET);
         3'h6: condTrue = (thirdCounter_reg == CNT_RESET);
         default: condTrue = 1'b0;
      endcase
      condTrue = condTrue ^ instr[3];
   end

   always_comb
   begin
      target = {1'b0, pc_reg} + 6'h01;
      moveOn = 1'b1;
      goStrobe = 1'b0;
      progHalt = 1'b0;
      waitDone = 1'b0;
      intSet = 1'b0;
      casez (instr)
         8'b0???_????:
         begin
            if (condTrue)
               target = {1'b0, pc_reg} + 6'({3'h0, instr[6:4]}) + 6'h01;
            else if (instr[6:4] == 3'h0)
               moveOn = 1'b0;
         end
         8'b100?_????:
         begin
            moveOn = waitArmed_reg & ovfPend_reg & (waitCnt_reg == 6'h01);
            waitDone = moveOn;
         end
         8'b1010_????:
         begin
            if (condTrue && labelValid_reg)
               target = {1'b0, label_reg};
         end
         OP_WAIT_CMP: moveOn = (macTimer >= timerCompareValue);
         OP_WAIT_REG:
         begin
            moveOn = (firstCounter_reg == CNT_RESET) | (ovfPend_reg & (firstCounter_reg == 8'h01));
            waitDone = moveOn;
         end
         OP_INT: intSet = 1'b1;
         OP_PROG_HALT: progHalt = 1'b1;
         8'b110?_????:
         begin
            if (instr[4:0] >= STROBE_CODE_FIELD_RADIO_FIRST && instr[4:0] <= STROBE_CODE_FIELD_RADIO_LAST)
            begin
               moveOn = 1'b0;
               goStrobe = 1'b1;
            end
         end
         default: moveOn = 1'b1;
      endcase
   end
   assign endRun = stepGo & moveOn & ~progHalt & (target > {1'b0, PC_LAST});

   // ************************************************************
   // sequencer
   // ************************************************************
   logic clearMem;
   assign clearMem = (stepGo & progHalt) | immHalt;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_reg <= S_IDLE;
         pc_reg <= PC_FIRST;
      end
      else if (clearMem || endRun || (stepGo && timeoutHit))
      begin
         state_reg <= S_IDLE;
         pc_reg <= PC_FIRST;
      end
      else if (immLaunch)
      begin
         state_reg <= S_RUN;
         pc_reg <= PC_FIRST;
      end
      else if (stepGo && goStrobe)
         state_reg <= S_STROBE;
      else if (stepGo && moveOn)
         pc_reg <= target[4:0];
      else if (state_reg == S_STROBE && strobeValid && !strobeImm && radioAck)
      begin
         state_reg <= S_RUN;
         if (pc_reg == PC_LAST)
            state_reg <= S_IDLE;
         else
            pc_reg <= pc_reg + 5'h01;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || clearMem)
      begin
         labelValid_reg <= 1'b0;
         label_reg <= PC_FIRST;
      end
      else if (stepGo && instr == OP_LABEL)
      begin
         labelValid_reg <= 1'b1;
         label_reg <= (pc_reg == PC_LAST) ? pc_reg : pc_reg + 5'h01;
      end
   end

   // ************************************************************
   // program memory
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (sys_rst || clearMem)
         wrPtr_reg <= PC_FIRST;
      else if (strobeWr && wrByte[7:5] != 3'h7 && wrPtr_reg <= PC_LAST)
         wrPtr_reg <= wrPtr_reg + 5'h01;
   end

   // writes beyond the last slot are dropped; the pointer parks one past the end
   genvar gi;
   generate
      for (gi = 0; gi < MEM_DEPTH; gi++)
      begin : g_mem
         always_ff @(posedge clk)
         begin
            if (sys_rst || clearMem)
               progMem[gi] <= OP_NOOP;
            else if (strobeWr && wrByte[7:5] != 3'h7 && wrPtr_reg == 5'(gi))
               progMem[gi] <= wrByte;
         end
      end
   endgenerate

   // ************************************************************
   // immediate strobes and radio port
   // ************************************************************
   // one-deep: a second immediate written before the first runs replaces it
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         immPend_reg <= 1'b0;
         immOp_reg <= OP_NOOP;
      end
      else if (strobeWr && wrByte[7:5] == 3'h7)
      begin
         immPend_reg <= 1'b1;
         immOp_reg <= wrByte;
      end
      else if (immGo)
         immPend_reg <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         strobeValid <= 1'b0;
         strobeCode <= 5'h00;
         strobeImm <= 1'b0;
      end
      else if (strobeValid && radioAck)
         strobeValid <= 1'b0;
      else if (immRadio)
      begin
         strobeValid <= 1'b1;
         strobeCode <= immOp_reg[4:0];
         strobeImm <= 1'b1;
      end
      else if (stepGo && goStrobe)
      begin
         strobeValid <= 1'b1;
         strobeCode <= instr[4:0];
         strobeImm <= 1'b0;
      end
   end

   // ************************************************************
   // overflow bookkeeping and counted waits
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (sys_rst || state_reg == S_IDLE)
         ovfPend_reg <= 1'b0;
      else if (macOverflow)
         ovfPend_reg <= 1'b1;
      else if (stepGo)
         ovfPend_reg <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || !stepGo)
      begin
         if (sys_rst)
         begin
            waitArmed_reg <= 1'b0;
            waitCnt_reg <= 6'h00;
         end
      end
      else if (instr[7:5] != 3'h4 || moveOn)
         waitArmed_reg <= 1'b0;
      else if (!waitArmed_reg)
      begin
         waitArmed_reg <= 1'b1;
         waitCnt_reg <= (instr[4:0] == 5'h00) ? WAIT_FULL : {1'b0, instr[4:0]};
      end
      else if (ovfPend_reg)
         waitCnt_reg <= waitCnt_reg - 6'h01;
   end

   // ************************************************************
   // data registers
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rngStale_reg <= 1'b0;
      else if (stepGo && instr == OP_RANDOM)
         rngStale_reg <= 1'b1;
      else if (tick)
         rngStale_reg <= 1'b0;
   end

   // the sample freezes from a load until the next step, hence a repeat on back-to-back loads
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rngHeld_reg <= 8'h00;
      else if (!rngStale_reg)
         rngHeld_reg <= rngOutput;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         firstCounter_reg <= CNT_RESET;
      else if (stepGo && instr == OP_RANDOM)
         firstCounter_reg <= rngHeld_reg & (8'hFF >> (4'h8 - randBits));
      else if (stepGo && instr == OP_WAIT_REG && ovfPend_reg && firstCounter_reg != CNT_RESET)
         firstCounter_reg <= firstCounter_reg - 8'h01;
      else if (apbWr && paddr == OFS_FIRST)
         firstCounter_reg <= pwdata[7:0];
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         secondCounter_reg <= CNT_RESET;
      else if (stepGo && instr == OP_SECOND_INC)
         secondCounter_reg <= secondPlus;
      else if (stepGo && instr == OP_SECOND_DEC)
         secondCounter_reg <= secondCounter_reg - 8'h01;
      else if (stepGo && instr[7:3] == 5'b1011_0)
         secondCounter_reg <= (secondCounter_reg == 8'hFF || secondPlus > {5'h00, instr[2:0]})
                            ? {5'h00, instr[2:0]} : secondPlus;
      else if (apbWr && paddr == OFS_SECOND)
         secondCounter_reg <= pwdata[7:0];
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         thirdCounter_reg <= CNT_RESET;
      else if (stepGo && instr == OP_THIRD_DEC)
         thirdCounter_reg <= thirdCounter_reg - 8'h01;
      else if (apbWr && paddr == OFS_THIRD)
         thirdCounter_reg <= pwdata[7:0];
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         timeout_reg <= TIMEOUT_RESET;
      else if (apbWr && paddr == OFS_TIMEOUT)
         timeout_reg <= pwdata[7:0];
      else if (macOverflow && state_reg != S_IDLE && timeout_reg != TIMEOUT_FREE && timeout_reg != CNT_RESET)
         timeout_reg <= timeout_reg - 8'h01;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         cpuCtrl_reg <= 1'b0;
      else if (apbWr && paddr == OFS_CTRL)
         cpuCtrl_reg <= pwdata[CTRL_CPU_BIT];
   end

   // ************************************************************
   // flags
   // ************************************************************
   logic ackWr;
   logic haltSet;
   assign ackWr = apbWr & (paddr == OFS_STATUS);
   assign haltSet = clearMem | endRun | (stepGo & timeoutHit)
                  | (state_reg == S_STROBE && strobeValid && !strobeImm && radioAck && pc_reg == PC_LAST);

   // a raise in the same cycle as an acknowledge wins
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         haltFlag <= 1'b0;
         waitDoneFlag <= 1'b0;
         programIntFlag <= 1'b0;
      end
      else
      begin
         haltFlag <= haltSet | (haltFlag & ~(ackWr & pwdata[STAT_HALT_BIT]));
         waitDoneFlag <= (stepGo & waitDone) | (waitDoneFlag & ~(ackWr & pwdata[STAT_WAIT_BIT]));
         programIntFlag <= (stepGo & intSet) | (programIntFlag & ~(ackWr & pwdata[STAT_INT_BIT]));
      end
   end
   assign radioIrq = haltFlag | waitDoneFlag | programIntFlag;

   // ************************************************************
   // read data
   // ************************************************************
   always_comb
   begin
      rdData = 8'h00;
      case (paddr)
         OFS_STROBE: rdData = (state_reg != S_IDLE && !immPend_reg && !(strobeValid && strobeImm)) ? instr : OP_NOOP;
         OFS_FIRST: rdData = firstCounter_reg;
         OFS_SECOND: rdData = secondCounter_reg;
         OFS_THIRD: rdData = thirdCounter_reg;
         OFS_TIMEOUT: rdData = timeout_reg;
         OFS_CTRL: rdData = {7'h00, cpuCtrl_reg};
         OFS_STATUS: rdData = {4'h0, state_reg != S_IDLE, programIntFlag, waitDoneFlag, haltFlag};
         default: rdData = 8'h00;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         prdata <= 32'h0000_0000;
      else if (apbRd)
         prdata <= {24'h00_0000, rdData};
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_irq_or;
      @(posedge clk) disable iff (sys_rst) radioIrq == (haltFlag | waitDoneFlag | programIntFlag);
   endproperty
   a_irq_or: assert property (p_irq_or) else $error("irq not or of flags");
   property p_int_flag;
      @(posedge clk) disable iff (sys_rst) (stepGo && instr == OP_INT) |=> programIntFlag;
   endproperty
   a_int_flag: assert property (p_int_flag) else $error("int op left flag clear");
   property p_flag_hold;
      @(posedge clk) disable iff (sys_rst) (haltFlag && !ackWr) |=> haltFlag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("halt flag dropped without ack");
   property p_halt_clear;
      @(posedge clk) disable iff (sys_rst) immHalt |=> (progMem[0] == OP_NOOP && wrPtr_reg == PC_FIRST && haltFlag);
   endproperty
   a_halt_clear: assert property (p_halt_clear) else $error("stop left memory");
   property p_end_keep;
      @(posedge clk) disable iff (sys_rst) (endRun && !strobeWr) |=> (progMem[0] == $past(progMem[0]) && haltFlag);
   endproperty
   a_end_keep: assert property (p_end_keep) else $error("end of program changed memory");
   property p_third_dec;
      @(posedge clk) disable iff (sys_rst) (stepGo && instr == OP_THIRD_DEC) |=>
         thirdCounter_reg == $past(thirdCounter_reg) - 8'h01;
   endproperty
   a_third_dec: assert property (p_third_dec) else $error("third counter not decremented");
   property p_second_inc;
      @(posedge clk) disable iff (sys_rst) (stepGo && instr == OP_SECOND_INC) |=>
         secondCounter_reg == $past(secondCounter_reg) + 8'h01;
   endproperty
   a_second_inc: assert property (p_second_inc) else $error("second counter not incremented");
   property p_imm_first;
      @(posedge clk) disable iff (sys_rst) (strobeValid && strobeImm && !radioAck) |=>
         (strobeValid && strobeImm && $stable(strobeCode));
   endproperty
   a_imm_first: assert property (p_imm_first) else $error("program stepped over immediate");
   property p_free_timeout;
      @(posedge clk) disable iff (sys_rst) (timeout_reg == TIMEOUT_FREE && !apbWr) |=> timeout_reg == TIMEOUT_FREE;
   endproperty
   a_free_timeout: assert property (p_free_timeout) else $error("free timeout moved");
   property p_step_rate;
      @(posedge clk) disable iff (sys_rst) tick |=> !tick [*4] ##1 tick;
   endproperty
   a_step_rate: assert property (p_step_rate) else $error("step rate wrong");
   c_launch: cover property (@(posedge clk) disable iff (sys_rst) immLaunch);
   c_wait_done: cover property (@(posedge clk) disable iff (sys_rst) stepGo && waitDone);
   c_prog_strobe: cover property (@(posedge clk) disable iff (sys_rst) strobeValid && !strobeImm && radioAck);
endmodule : rsp_core
`default_nettype wire

/* File: hdl/rsp_pkg.sv */
package rsp_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int EXEC_HZ = 8_000_000;
   localparam int TICK_DIV = CLK_HZ / EXEC_HZ;
   localparam logic [2:0] TICK_LAST = 3'(TICK_DIV - 1);
   localparam int MEM_DEPTH = 24;
   localparam logic [4:0] PC_LAST = 5'h17;
   localparam logic [4:0] PC_FIRST = 5'h00;
   localparam logic [7:0] OFS_STROBE = 8'h00;
   localparam logic [7:0] OFS_FIRST = 8'h04;
   localparam logic [7:0] OFS_SECOND = 8'h08;
   localparam logic [7:0] OFS_THIRD = 8'h0C;
   localparam logic [7:0] OFS_TIMEOUT = 8'h10;
   localparam logic [7:0] OFS_CTRL = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam int CTRL_CPU_BIT = 0;
   localparam int STAT_HALT_BIT = 0;
   localparam int STAT_WAIT_BIT = 1;
   localparam int STAT_INT_BIT = 2;
   localparam int STAT_RUN_BIT = 3;
   localparam logic [7:0] OP_NOOP = 8'hC0;
   localparam logic [7:0] OP_PROG_HALT = 8'hDF;
   localparam logic [7:0] OP_WAIT_CMP = 8'hB8;
   localparam logic [7:0] OP_INT = 8'hB9;
   localparam logic [7:0] OP_LABEL = 8'hBA;
   localparam logic [7:0] OP_WAIT_REG = 8'hBB;
   localparam logic [7:0] OP_RANDOM = 8'hBC;
   localparam logic [7:0] OP_SECOND_INC = 8'hBD;
   localparam logic [7:0] OP_SECOND_DEC = 8'hBE;
   localparam logic [7:0] OP_THIRD_DEC = 8'hBF;
   localparam logic [7:0] OP_IMM_LAUNCH = 8'hE1;
   localparam logic [7:0] OP_IMM_HALT = 8'hFF;
   localparam logic [4:0] STROBE_CODE_FIELD_RADIO_FIRST = 5'h01;
   localparam logic [4:0] STROBE_CODE_FIELD_RADIO_LAST = 5'h0A;
   localparam logic [7:0] TIMEOUT_FREE = 8'hFF;
   localparam logic [5:0] WAIT_FULL = 6'h20;
   localparam logic [3:0] RAND_FULL = 4'h8;
   localparam logic [7:0] CNT_RESET = 8'h00;
   localparam logic [7:0] TIMEOUT_RESET = 8'hFF;
   typedef enum logic [1:0] {S_IDLE, S_RUN, S_STROBE} rsp_state_t;
endpackage : rsp_pkg

/* File: verification/rsp_radio_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// radio side model
// ****************
// acks each strobe request after a few cycles; a pulse so no stale level lingers
module rsp_radio_model #(parameter int DLY = 3)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic strobeValid,
   output logic radioAck
);
   logic [3:0] cnt;
   always_ff @(posedge clk)
   begin
      if (sys_rst || !strobeValid || radioAck)
      begin
         cnt <= 4'h0;
         radioAck <= 1'b0;
      end
      else
      begin
         cnt <= cnt + 4'h1;
         radioAck <= (cnt == 4'(DLY));
      end
   end
endmodule : rsp_radio_model
`default_nettype wire

/* File: verification/radio_strobe_program_core_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module radio_strobe_program_core_tb_top;
   import rsp_pkg::*;
   logic clk, sys_rst, psel, penable, pwrite, macOverflow, ccaIn, sfdIn, radioAck, pready, pslverr, e;
   logic strobeValid, strobeImm, radioIrq, haltFlag, waitDoneFlag, programIntFlag;
   logic [7:0] paddr, rngOutput;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] macTimer, timerCompareValue;
   logic [4:0] strobeCode;
   int num_errors = 0;
   int checked = 0;
   rsp_core rsp_core_i (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .macOverflow(macOverflow), .macTimer(macTimer), .timerCompareValue(timerCompareValue), .ccaIn(ccaIn),
      .sfdIn(sfdIn), .rngOutput(rngOutput), .strobeValid(strobeValid), .strobeCode(strobeCode),
      .strobeImm(strobeImm), .radioAck(radioAck), .radioIrq(radioIrq), .haltFlag(haltFlag),
      .waitDoneFlag(waitDoneFlag), .programIntFlag(programIntFlag));
   rsp_radio_model rsp_radio_model_i (.clk(clk), .sys_rst(sys_rst), .strobeValid(strobeValid),
      .radioAck(radioAck));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ****************
   // shared tasks
   // ****************
   task summarize;
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // apb master: hold the request until pready is seen at an access edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      for (n = 0; n < 20 && pready !== 1'b1; n++)
         @(posedge clk);
      if (n == 20)
      begin
         num_errors++;
         summarize;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task waitHalt;
      int n;
      for (n = 0; n < 3000 && haltFlag !== 1'b1; n++)
         @(posedge clk);
      if (n == 3000)
      begin
         num_errors++;
         summarize;
      end
   endtask : waitHalt
   task run;
      apb(1'b1, OFS_STROBE, 32'(OP_IMM_LAUNCH));
      waitHalt;
   endtask : run
   task clr;
      apb(1'b1, OFS_STATUS, 32'h0000_0007);
      @(posedge clk);
   endtask : clr
   task load(input logic [7:0] p[$]);
      foreach (p[i]) apb(1'b1, OFS_STROBE, 32'(p[i]));
   endtask : load
   task ovf;
      @(posedge clk);
      macOverflow <= 1'b1;
      @(posedge clk);
      macOverflow <= 1'b0;
      repeat (10) @(posedge clk);
   endtask : ovf
   // ****************
   // main sequence
   // ****************
   initial
   begin
      int n;
      {sys_rst, psel, penable, pwrite, macOverflow, ccaIn, sfdIn} = 7'h40;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      rngOutput = 8'hA5;
      macTimer = 16'h0000;
      timerCompareValue = 16'h0000;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      apb(1'b0, OFS_TIMEOUT, 0); chk(q, 32'h0000_00FF);
      apb(1'b0, 8'h40, 0); chk(e, 1);
      apb(1'b1, OFS_CTRL, 1);
      load('{8'h12, 8'hBE, 8'hBD, 8'hBD, 8'hBF, 8'hB9, 8'h77});
      run; chk(haltFlag, 1);
      chk(programIntFlag, 1);
      chk(radioIrq, 1);
      apb(1'b0, OFS_SECOND, 0); chk(q, 2);
      apb(1'b0, OFS_THIRD, 0); chk(q, 32'h0000_00FF);
      clr; chk(radioIrq, 0);
      run; apb(1'b0, OFS_SECOND, 0); chk(q, 4);
      apb(1'b0, OFS_THIRD, 0); chk(q, 32'h0000_00FE);
      clr; apb(1'b1, OFS_STROBE, 32'(OP_IMM_HALT)); waitHalt; clr;
      load('{8'hBC, 8'hB3, 8'hDF}); apb(1'b1, OFS_SECOND, 32'h0000_00FF);
      run; apb(1'b0, OFS_FIRST, 0); chk(q, 32'h0000_00A5);
      apb(1'b0, OFS_SECOND, 0); chk(q, 3);
      clr; apb(1'b1, OFS_SECOND, 32'h0000_00FF);
      run; apb(1'b0, OFS_SECOND, 0); chk(q, 32'h0000_00FF);
      clr; load('{8'h82}); apb(1'b1, OFS_STROBE, 32'(OP_IMM_LAUNCH));
      repeat (15) @(posedge clk);
      ovf; chk(waitDoneFlag, 0);
      ovf; chk(waitDoneFlag, 1);
      waitHalt; clr; apb(1'b1, OFS_STROBE, 32'(OP_IMM_HALT)); waitHalt; clr;
      load('{8'h80}); apb(1'b1, OFS_TIMEOUT, 2); apb(1'b1, OFS_STROBE, 32'(OP_IMM_LAUNCH));
      repeat (15) @(posedge clk);
      ovf; ovf; waitHalt; chk(waitDoneFlag, 0);
      apb(1'b1, OFS_TIMEOUT, 32'h0000_00FF); clr;
      apb(1'b1, OFS_STROBE, 32'h0000_00E3);
      for (n = 0; n < 50 && strobeValid !== 1'b1; n++)
         @(posedge clk);
      chk(strobeValid, 1);
      chk(strobeCode, 3);
      chk(strobeImm, 1);
      repeat (20) @(posedge clk);
      chk(strobeValid, 0);
      apb(1'b1, OFS_STROBE, 32'(OP_IMM_HALT));
      waitHalt;
      clr;
      load('{8'h00, 8'hC4});
      apb(1'b1, OFS_STROBE, 32'(OP_IMM_LAUNCH));
      repeat (15) @(posedge clk);
      apb(1'b1, OFS_STROBE, 32'h0000_00E5);
      for (n = 0; n < 50 && strobeValid !== 1'b1; n++)
         @(posedge clk);
      chk(strobeCode, 5);
      chk(strobeImm, 1);
      repeat (20) @(posedge clk);
      ccaIn <= 1'b1;
      for (n = 0; n < 50 && strobeValid !== 1'b1; n++)
         @(posedge clk);
      chk(strobeCode, 4);
      chk(strobeImm, 0);
      waitHalt;
      chk(haltFlag, 1);
      clr;
      apb(1'b1, OFS_STROBE, 32'(OP_IMM_HALT));
      waitHalt;
      clr;
      apb(1'b1, OFS_SECOND, 32'h0000_0003);
      apb(1'b1, OFS_FIRST, 32'h0000_0000);
      load('{8'hBA, 8'hBE, 8'hAD, 8'hB8, 8'hBB});
      run;
      apb(1'b0, OFS_SECOND, 0);
      chk(q, 0);
      chk(waitDoneFlag, 1);
      summarize;
   end
endmodule : radio_strobe_program_core_tb_top
`default_nettype wire
